// >>> ilsa_pkg.sv
// shared constants and types of the integer logic, shift and bit datapath
// assumes: included by name in compile order before every module of the block
// ==========================================================================
// operations, sizes and sequencer states
package ilsa_pkg;
	typedef enum logic [4:0] {
		OP_UNSIGNED_DIVIDE = 5'h00,
		OP_SIGNED_DIVIDE = 5'h01,
		OP_COMPARE = 5'h02,
		OP_NEGATE = 5'h03,
		OP_SIGN_EXTEND = 5'h04,
		OP_ZERO_EXTEND = 5'h05,
		OP_AND = 5'h06,
		OP_OR = 5'h07,
		OP_XOR = 5'h08,
		OP_COMPLEMENT = 5'h09,
		OP_ARITH_SHIFT_LEFT = 5'h0a,
		OP_ARITH_SHIFT_RIGHT = 5'h0b,
		OP_LOGIC_SHIFT_LEFT = 5'h0c,
		OP_LOGIC_SHIFT_RIGHT = 5'h0d,
		OP_ROTATE_LEFT = 5'h0e,
		OP_ROTATE_RIGHT = 5'h0f,
		OP_ROTATE_CARRY_LEFT = 5'h10,
		OP_ROTATE_CARRY_RIGHT = 5'h11,
		OP_BIT_SET = 5'h12,
		OP_BIT_CLEAR = 5'h13,
		OP_BIT_INVERT = 5'h14,
		OP_BIT_TEST = 5'h15,
		OP_CARRY_AND_BIT = 5'h16,
		OP_CARRY_AND_INVERTED_BIT = 5'h17
	} ilsa_op_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_EXEC = 5'h02,
		ST_DIV = 5'h04,
		ST_MRD = 5'h08,
		ST_MDAT = 5'h10
	} ilsa_state_t;

	// ======================================================================
	// operand sizes
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_LONG = 2'h2;

	// ======================================================================
	// condition flag positions, register port map and reset values
	localparam int FLG_C = 0;
	localparam int FLG_V = 1;
	localparam int FLG_Z = 2;
	localparam int FLG_N = 3;
	localparam logic [3:0] ADDR_FLAGS = 4'h8;
	localparam logic [31:0] GR_RESET = 32'h0000_0000;
	localparam logic [3:0] FLAGS_RESET = 4'h0;
	localparam logic [5:0] DIV_STEPS = 6'h20;
endpackage

// >>> ilsa_divider.sv
// iterative restoring divider, 32-bit dividend by 16-bit divisor
// assumes: operands are magnitudes; the caller fixes signs and picks widths
`timescale 1ns/10ps

// ==========================================================================
// one quotient bit per clock, result pulse after the last step
module ilsa_divider (
	input wire logic sys_clk_i, // core clock
	input wire logic sys_rst_i, // synchronous reset, active high
	input wire logic start_i, // one-cycle start, ignored while busy
	input wire logic [31:0] dividend_i, // dividend magnitude
	input wire logic [15:0] divisor_i, // divisor magnitude
	output logic [31:0] quot_o, // quotient, all ones on divide by zero
	output logic [15:0] rem_o, // remainder
	output logic done_o // one-cycle pulse, result valid
);
	logic [31:0] quot_q;
	logic [15:0] rem_q;
	logic [15:0] dvs_q;
	logic [5:0] cnt_q;
	logic busy_q;
	logic done_q;
	logic [16:0] shift_c;
	logic fits_c;
	logic [16:0] diff_c;

	// trial subtraction of the shifted partial remainder
	assign shift_c = {rem_q, quot_q[31]};
	assign fits_c = shift_c >= {1'b0, dvs_q};
	assign diff_c = shift_c - {1'b0, dvs_q};

	// step sequencer; a zero divisor simply runs out with all ones
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			quot_q <= 32'h0000_0000;
			rem_q <= 16'h0000;
			dvs_q <= 16'h0000;
			cnt_q <= 6'h00;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (!busy_q && start_i) begin
				quot_q <= dividend_i;
				rem_q <= 16'h0000;
				dvs_q <= divisor_i;
				cnt_q <= ilsa_pkg::DIV_STEPS;
				busy_q <= 1'b1;
			end else if (busy_q) begin
				quot_q <= {quot_q[30:0], fits_c};
				rem_q <= fits_c ? diff_c[15:0] : shift_c[15:0];
				cnt_q <= cnt_q - 6'h01;
				if (cnt_q == 6'h01) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end
			end
		end
	end

	assign quot_o = quot_q;
	assign rem_o = rem_q;
	assign done_o = done_q;
endmodule

// >>> ilsa_alu.sv
// integer logic, shift, divide and bit manipulation datapath with its
// general register file and condition flags
// assumes: one command at a time from the decoder, accepted while ready;
// a one-byte memory port whose read data stand in the cycle after the read
// What this block does
// - unsigned divide: 16 by 8 or 32 by 16 into quotient and remainder
// - signed divide in the same two forms on two's-complement operands
// - compare subtracts source or literal, sets flags, keeps destination
// - negate replaces destination with zero minus its value
// - sign extend widens byte to word or word to longword
// - zero extend does the same widening with zero fill
// - and, or, exclusive or with a register or literal into destination
// - complement inverts every bit of the destination
// - arithmetic shifts by one, right shift keeps the sign bit
// - logical shifts by one, vacated bit filled with zero
// - plain rotates move the outgoing bit into the vacated end
// - carry rotates pass the outgoing bit to carry, old carry enters
// - bit number from a 3-bit literal or low 3 bits of a register
// - bit set forces the chosen bit of a byte operand to one
// - bit clear forces the chosen bit of a byte operand to zero
// - bit invert toggles the chosen bit and writes the byte back
// - bit test loads zero flag with the inverse bit, operand untouched
// - carry and bit: carry becomes carry and the chosen bit
// - carry and inverted bit, bit number only from the literal
// - flags hold negative, zero, overflow and carry
// - register file of eight 32-bit registers, 16-bit and 8-bit halves
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/10ps

// ==========================================================================
// top of the datapath
module ilsa_alu (
	input wire logic sys_clk_i, // 40 MHz core clock
	input wire logic sys_rst_i, // synchronous reset, active high
	input wire logic cmd_valid_i, // command offered
	input wire logic [4:0] cmd_op_i, // operation code
	input wire logic [1:0] cmd_size_i, // byte, word or longword
	input wire logic [3:0] cmd_dst_i, // destination register select
	input wire logic [3:0] cmd_src_i, // source register select
	input wire logic cmd_use_imm_i, // take literal instead of source
	input wire logic [31:0] cmd_imm_i, // literal operand, bit number in [2:0]
	input wire logic cmd_mem_i, // bit operation on a memory byte
	input wire logic [23:0] cmd_mem_addr_i, // byte address of memory operand
	output logic cmd_ready_o, // command accepted when high with valid
	output logic done_o, // one-cycle pulse, command finished
	output logic [3:0] flags_o, // negative, zero, overflow, carry
	output logic mem_rd_o, // one-cycle memory read strobe
	output logic mem_wr_o, // one-cycle memory write strobe
	output logic [23:0] mem_addr_o, // memory byte address
	output logic [7:0] mem_wdata_o, // memory write byte
	input wire logic [7:0] mem_rdata_i, // read byte, cycle after the strobe
	input wire logic [3:0] reg_addr_i, // 0-7 registers, 8 flags
	input wire logic [31:0] reg_wdata_i, // register port write data
	input wire logic reg_wr_i, // register port write strobe
	input wire logic reg_rd_i, // register port read strobe
	output logic [31:0] reg_rdata_o // read data, cycle after the strobe
);
	// ======================================================================
	// helpers
	function automatic logic [31:0] size_mask(input logic [1:0] sz);
		case (sz)
			ilsa_pkg::SZ_BYTE: size_mask = 32'h0000_00ff;
			ilsa_pkg::SZ_WORD: size_mask = 32'h0000_ffff;
			default: size_mask = 32'hffff_ffff;
		endcase
	endfunction

	function automatic logic [31:0] top_bit(input logic [1:0] sz);
		case (sz)
			ilsa_pkg::SZ_BYTE: top_bit = 32'h0000_0080;
			ilsa_pkg::SZ_WORD: top_bit = 32'h0000_8000;
			default: top_bit = 32'h8000_0000;
		endcase
	endfunction

	function automatic logic is_neg(input logic [31:0] v, input logic [1:0] sz);
		is_neg = |(v & top_bit(sz));
	endfunction

	// byte sel[3]=1 is the low half, word sel[3]=1 is the upper extension
	function automatic logic [31:0] rd_gr(input logic [31:0] v, input logic [1:0] sz,
			input logic [3:0] sel);
		case (sz)
			ilsa_pkg::SZ_BYTE: rd_gr = sel[3] ? {24'h0, v[7:0]} : {24'h0, v[15:8]};
			ilsa_pkg::SZ_WORD: rd_gr = sel[3] ? {16'h0, v[31:16]} : {16'h0, v[15:0]};
			default: rd_gr = v;
		endcase
	endfunction

	function automatic logic [31:0] wr_gr(input logic [31:0] old, input logic [31:0] val,
			input logic [1:0] sz, input logic [3:0] sel);
		case (sz)
			ilsa_pkg::SZ_BYTE: wr_gr = sel[3] ? {old[31:8], val[7:0]} :
				{old[31:16], val[7:0], old[7:0]};
			ilsa_pkg::SZ_WORD: wr_gr = sel[3] ? {val[15:0], old[15:0]} :
				{old[31:16], val[15:0]};
			default: wr_gr = val;
		endcase
	endfunction

	function automatic logic [3:0] nzvc(input logic [31:0] r, input logic [1:0] sz,
			input logic v, input logic c);
		nzvc = {is_neg(r, sz), (r & size_mask(sz)) == 32'h0, v, c};
	endfunction

	// ======================================================================
	// state
	logic [31:0] gr_q [8];
	logic [3:0] flags_q;
	ilsa_pkg::ilsa_state_t state_q;
	ilsa_pkg::ilsa_op_t op_q;
	logic [1:0] size_q;
	logic [3:0] dst_q;
	logic [3:0] src_q;
	logic use_imm_q;
	logic [31:0] imm_q;
	logic mem_q;
	logic ready_q;
	logic done_q;
	logic mem_rd_q;
	logic mem_wr_q;
	logic [23:0] mem_addr_q;
	logic [7:0] mem_wdata_q;
	logic [31:0] reg_rdata_q;
	logic q_neg_q;
	logic r_neg_q;
	logic dvs_zero_q;
	logic div_start_q;
	logic [31:0] div_quot;
	logic [15:0] div_rem;
	logic div_done;

	// ======================================================================
	// operand fetch
	logic [31:0] dst_full;
	logic [31:0] src_full;
	logic [31:0] m;
	logic [31:0] a;
	logic [31:0] b;
	logic [1:0] half_sz;
	logic [1:0] dbl_sz;
	logic [2:0] bit_pos;
	logic [7:0] bop;
	logic bit_val;
	logic is_div;
	logic [31:0] dvd_raw;
	logic [31:0] dvs_raw;
	logic [31:0] src_byte;
	logic [31:0] dst_byte;

	assign dst_full = gr_q[dst_q[2:0]];
	assign src_full = gr_q[src_q[2:0]];
	assign m = size_mask(size_q);
	assign a = rd_gr(dst_full, size_q, dst_q);
	assign b = use_imm_q ? (imm_q & m) : rd_gr(src_full, size_q, src_q);
	assign half_sz = size_q - 2'h1;
	assign dbl_sz = size_q + 2'h1;
	// the inverted carry form has no register bit number
	assign src_byte = rd_gr(src_full, ilsa_pkg::SZ_BYTE, src_q);
	assign dst_byte = rd_gr(dst_full, ilsa_pkg::SZ_BYTE, dst_q);
	assign bit_pos = (use_imm_q || op_q == ilsa_pkg::OP_CARRY_AND_INVERTED_BIT) ?
		imm_q[2:0] : src_byte[2:0];
	assign bop = mem_q ? mem_rdata_i : dst_byte[7:0];
	assign bit_val = bop[bit_pos];
	assign is_div = op_q == ilsa_pkg::OP_UNSIGNED_DIVIDE ||
		op_q == ilsa_pkg::OP_SIGNED_DIVIDE;
	assign dvd_raw = rd_gr(dst_full, dbl_sz, dst_q);
	assign dvs_raw = rd_gr(src_full, size_q, src_q);

	// ======================================================================
	// divide: magnitudes in, signs restored on the way out
	logic dvd_neg;
	logic dvs_neg;
	logic [31:0] dvd_mag;
	logic [31:0] dvs_mag;
	logic [31:0] q_fix;
	logic [31:0] r_fix;

	assign dvd_neg = op_q == ilsa_pkg::OP_SIGNED_DIVIDE && is_neg(dvd_raw, dbl_sz);
	assign dvs_neg = op_q == ilsa_pkg::OP_SIGNED_DIVIDE && is_neg(dvs_raw, size_q);
	assign dvd_mag = dvd_neg ? (32'h0 - dvd_raw) & size_mask(dbl_sz) : dvd_raw;
	assign dvs_mag = dvs_neg ? (32'h0 - dvs_raw) & m : dvs_raw;
	assign q_fix = (q_neg_q ? 32'h0 - div_quot : div_quot) & m;
	assign r_fix = (r_neg_q ? 32'h0 - {16'h0, div_rem} : {16'h0, div_rem}) & m;

	// divide latency is a fixed 32 steps for either dividend width, no early exit
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			q_neg_q <= 1'b0;
			r_neg_q <= 1'b0;
			dvs_zero_q <= 1'b0;
			div_start_q <= 1'b0;
		end else begin
			div_start_q <= state_q == ilsa_pkg::ST_EXEC && is_div;
			if (state_q == ilsa_pkg::ST_EXEC) begin
				q_neg_q <= dvd_neg ^ dvs_neg;
				r_neg_q <= dvd_neg;
				dvs_zero_q <= dvs_raw == 32'h0;
			end
		end
	end

	ilsa_divider u_div (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.start_i(div_start_q),
		.dividend_i(dvd_mag),
		.divisor_i(dvs_mag[15:0]),
		.quot_o(div_quot),
		.rem_o(div_rem),
		.done_o(div_done)
	);

	// ======================================================================
	// result and flag computation
	logic [31:0] res_c;
	logic [1:0] wsz_c;
	logic wr_c;
	logic [3:0] fl_c;
	logic [7:0] bmod_c;
	logic [31:0] diff;
	logic [31:0] lo;
	logic a_top;
	logic c_in;

	assign diff = (a - b) & m;
	assign lo = a & size_mask(half_sz);
	assign a_top = is_neg(a, size_q);
	assign c_in = flags_q[ilsa_pkg::FLG_C];

	always_comb begin
		res_c = a;
		wsz_c = size_q;
		wr_c = 1'b1;
		fl_c = flags_q;
		bmod_c = bop;
		case (op_q)
			ilsa_pkg::OP_UNSIGNED_DIVIDE, ilsa_pkg::OP_SIGNED_DIVIDE: begin
				wsz_c = dbl_sz;
				res_c = size_q == ilsa_pkg::SZ_BYTE ? {16'h0, r_fix[7:0], q_fix[7:0]} :
					{r_fix[15:0], q_fix[15:0]};
				fl_c = {is_neg(q_fix, size_q), dvs_zero_q, 1'b0, c_in};
			end
			ilsa_pkg::OP_COMPARE: begin
				wr_c = 1'b0;
				fl_c = nzvc(diff, size_q, (a_top != is_neg(b, size_q)) &&
					(is_neg(diff, size_q) != a_top), b > a);
			end
			ilsa_pkg::OP_NEGATE: begin
				res_c = (32'h0 - a) & m;
				fl_c = nzvc(res_c, size_q, a == top_bit(size_q), a != 32'h0);
			end
			ilsa_pkg::OP_SIGN_EXTEND, ilsa_pkg::OP_ZERO_EXTEND: begin
				res_c = (op_q == ilsa_pkg::OP_SIGN_EXTEND && is_neg(lo, half_sz)) ?
					lo | (m & ~size_mask(half_sz)) : lo;
				fl_c = nzvc(res_c, size_q, 1'b0, c_in);
			end
			ilsa_pkg::OP_AND, ilsa_pkg::OP_OR, ilsa_pkg::OP_XOR: begin
				res_c = op_q == ilsa_pkg::OP_AND ? a & b :
					op_q == ilsa_pkg::OP_OR ? a | b : a ^ b;
				fl_c = nzvc(res_c, size_q, 1'b0, c_in);
			end
			ilsa_pkg::OP_COMPLEMENT: begin
				res_c = ~a & m;
				fl_c = nzvc(res_c, size_q, 1'b0, c_in);
			end
			ilsa_pkg::OP_ARITH_SHIFT_LEFT, ilsa_pkg::OP_LOGIC_SHIFT_LEFT: begin
				res_c = (a << 1) & m;
				fl_c = nzvc(res_c, size_q, op_q == ilsa_pkg::OP_ARITH_SHIFT_LEFT &&
					(a_top != is_neg(res_c, size_q)), a_top);
			end
			ilsa_pkg::OP_ARITH_SHIFT_RIGHT: begin
				res_c = (a >> 1) | (a_top ? top_bit(size_q) : 32'h0);
				fl_c = nzvc(res_c, size_q, 1'b0, a[0]);
			end
			ilsa_pkg::OP_LOGIC_SHIFT_RIGHT: begin
				res_c = a >> 1;
				fl_c = nzvc(res_c, size_q, 1'b0, a[0]);
			end
			ilsa_pkg::OP_ROTATE_LEFT: begin
				res_c = ((a << 1) & m) | {31'h0, a_top};
				fl_c = nzvc(res_c, size_q, 1'b0, a_top);
			end
			ilsa_pkg::OP_ROTATE_RIGHT: begin
				res_c = (a >> 1) | (a[0] ? top_bit(size_q) : 32'h0);
				fl_c = nzvc(res_c, size_q, 1'b0, a[0]);
			end
			ilsa_pkg::OP_ROTATE_CARRY_LEFT: begin
				res_c = ((a << 1) & m) | {31'h0, c_in};
				fl_c = nzvc(res_c, size_q, 1'b0, a_top);
			end
			ilsa_pkg::OP_ROTATE_CARRY_RIGHT: begin
				res_c = (a >> 1) | (c_in ? top_bit(size_q) : 32'h0);
				fl_c = nzvc(res_c, size_q, 1'b0, a[0]);
			end
			ilsa_pkg::OP_BIT_SET, ilsa_pkg::OP_BIT_CLEAR, ilsa_pkg::OP_BIT_INVERT: begin
				wsz_c = ilsa_pkg::SZ_BYTE;
				bmod_c[bit_pos] = op_q == ilsa_pkg::OP_BIT_SET ? 1'b1 :
					op_q == ilsa_pkg::OP_BIT_CLEAR ? 1'b0 : ~bit_val;
				res_c = {24'h0, bmod_c};
			end
			ilsa_pkg::OP_BIT_TEST: begin
				wr_c = 1'b0;
				fl_c[ilsa_pkg::FLG_Z] = ~bit_val;
			end
			ilsa_pkg::OP_CARRY_AND_BIT: begin
				wr_c = 1'b0;
				fl_c[ilsa_pkg::FLG_C] = c_in & bit_val;
			end
			ilsa_pkg::OP_CARRY_AND_INVERTED_BIT: begin
				wr_c = 1'b0;
				fl_c[ilsa_pkg::FLG_C] = c_in & ~bit_val;
			end
			default: begin
				wr_c = 1'b0;
			end
		endcase
	end

	// ======================================================================
	// sequencing
	logic exec_fire;
	logic mem_fire;
	logic div_fire;

	assign exec_fire = state_q == ilsa_pkg::ST_EXEC && !is_div && !mem_q;
	assign mem_fire = state_q == ilsa_pkg::ST_MDAT;
	assign div_fire = state_q == ilsa_pkg::ST_DIV && div_done;

	// command latch; only taken while idle so the operands stay put
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			op_q <= ilsa_pkg::OP_COMPARE;
			size_q <= ilsa_pkg::SZ_BYTE;
			dst_q <= 4'h0;
			src_q <= 4'h0;
			use_imm_q <= 1'b0;
			imm_q <= 32'h0000_0000;
			mem_q <= 1'b0;
		end else if (ready_q && cmd_valid_i) begin
			op_q <= ilsa_pkg::ilsa_op_t'(cmd_op_i);
			size_q <= cmd_size_i;
			dst_q <= cmd_dst_i;
			src_q <= cmd_src_i;
			use_imm_q <= cmd_use_imm_i;
			imm_q <= cmd_imm_i;
			mem_q <= cmd_mem_i;
		end
	end

	// state machine, ready and done
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			state_q <= ilsa_pkg::ST_IDLE;
			ready_q <= 1'b1;
			done_q <= 1'b0;
		end else begin
			done_q <= exec_fire || mem_fire || div_fire;
			case (state_q)
				ilsa_pkg::ST_IDLE: begin
					if (cmd_valid_i) begin
						state_q <= ilsa_pkg::ST_EXEC;
						ready_q <= 1'b0;
					end
				end
				ilsa_pkg::ST_EXEC: begin
					if (is_div) begin
						state_q <= ilsa_pkg::ST_DIV;
					end else if (mem_q) begin
						state_q <= ilsa_pkg::ST_MRD;
					end else begin
						state_q <= ilsa_pkg::ST_IDLE;
						ready_q <= 1'b1;
					end
				end
				ilsa_pkg::ST_DIV: begin
					if (div_done) begin
						state_q <= ilsa_pkg::ST_IDLE;
						ready_q <= 1'b1;
					end
				end
				ilsa_pkg::ST_MRD: begin
					state_q <= ilsa_pkg::ST_MDAT;
				end
				default: begin
					state_q <= ilsa_pkg::ST_IDLE;
					ready_q <= 1'b1;
				end
			endcase
		end
	end

	// memory byte port: read, then write back only for modifying forms
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			mem_rd_q <= 1'b0;
			mem_wr_q <= 1'b0;
			mem_addr_q <= 24'h00_0000;
			mem_wdata_q <= 8'h00;
		end else begin
			mem_rd_q <= state_q == ilsa_pkg::ST_EXEC && mem_q && !is_div;
			mem_wr_q <= mem_fire && wr_c;
			if (ready_q && cmd_valid_i) begin
				mem_addr_q <= cmd_mem_addr_i;
			end
			if (mem_fire) begin
				mem_wdata_q <= bmod_c;
			end
		end
	end

	// ======================================================================
	// register file and flags; datapath write-back beats a port write
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < 8; i++) begin
				gr_q[i] <= ilsa_pkg::GR_RESET;
			end
		end else if (wr_c && (exec_fire || div_fire)) begin
			gr_q[dst_q[2:0]] <= wr_gr(dst_full, res_c, wsz_c, dst_q);
		end else if (reg_wr_i && !reg_addr_i[3]) begin
			gr_q[reg_addr_i[2:0]] <= reg_wdata_i;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			flags_q <= ilsa_pkg::FLAGS_RESET;
		end else if (exec_fire || mem_fire || div_fire) begin
			flags_q <= fl_c;
		end else if (reg_wr_i && reg_addr_i == ilsa_pkg::ADDR_FLAGS) begin
			flags_q <= reg_wdata_i[3:0];
		end
	end

	// port read, unmapped addresses read zero
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			reg_rdata_q <= 32'h0000_0000;
		end else if (reg_rd_i) begin
			if (!reg_addr_i[3]) begin
				reg_rdata_q <= gr_q[reg_addr_i[2:0]];
			end else if (reg_addr_i == ilsa_pkg::ADDR_FLAGS) begin
				reg_rdata_q <= {28'h0, flags_q};
			end else begin
				reg_rdata_q <= 32'h0000_0000;
			end
		end
	end

	assign cmd_ready_o = ready_q;
	assign done_o = done_q;
	assign flags_o = flags_q;
	assign mem_rd_o = mem_rd_q;
	assign mem_wr_o = mem_wr_q;
	assign mem_addr_o = mem_addr_q;
	assign mem_wdata_o = mem_wdata_q;
	assign reg_rdata_o = reg_rdata_q;

	// ======================================================================
	// checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	logic exec_long;
	assign exec_long = exec_fire && size_q == ilsa_pkg::SZ_LONG;

	property p_div_time;
		state_q == ilsa_pkg::ST_EXEC && is_div |-> ##[34:36] done_q;
	endproperty
	a_div_time: assert property (p_div_time) else $error("divide latency wrong");

	property p_cmp_keep;
		exec_fire && op_q == ilsa_pkg::OP_COMPARE && !reg_wr_i |=> $stable(dst_full);
	endproperty
	a_cmp_keep: assert property (p_cmp_keep) else $error("compare changed dest");

	property p_neg;
		exec_long && op_q == ilsa_pkg::OP_NEGATE |=> dst_full == 32'h0 - $past(dst_full);
	endproperty
	a_neg: assert property (p_neg) else $error("negate result wrong");

	property p_not;
		exec_long && op_q == ilsa_pkg::OP_COMPLEMENT |=> dst_full == ~$past(dst_full);
	endproperty
	a_not: assert property (p_not) else $error("complement result wrong");

	property p_sign_extend_op;
		exec_long && op_q == ilsa_pkg::OP_SIGN_EXTEND |=>
			dst_full[31:16] == {16{$past(dst_full[15])}};
	endproperty
	a_sign_extend_op: assert property (p_sign_extend_op) else $error("sign extension wrong");

	property p_bit_test_op;
		exec_fire && op_q == ilsa_pkg::OP_BIT_TEST |=>
			flags_q[ilsa_pkg::FLG_Z] == !$past(bit_val);
	endproperty
	a_bit_test_op: assert property (p_bit_test_op) else $error("bit test zero flag wrong");

	property p_carry_and_inverted_bit;
		(exec_fire || mem_fire) && op_q == ilsa_pkg::OP_CARRY_AND_INVERTED_BIT |=>
			flags_q[ilsa_pkg::FLG_C] == ($past(c_in) && !$past(bop[imm_q[2:0]]));
	endproperty
	a_carry_and_inverted_bit: assert property (p_carry_and_inverted_bit) else $error("inverted carry and wrong");

	property p_rmw;
		state_q == ilsa_pkg::ST_EXEC && mem_q && use_imm_q && op_q == ilsa_pkg::OP_BIT_SET |=>
			mem_rd_o ##2 mem_wr_o && mem_wdata_o[imm_q[2:0]];
	endproperty
	a_rmw: assert property (p_rmw) else $error("bit set write-back wrong");

	property p_test_ro;
		state_q == ilsa_pkg::ST_EXEC && mem_q && (op_q == ilsa_pkg::OP_BIT_TEST ||
			op_q == ilsa_pkg::OP_CARRY_AND_BIT ||
			op_q == ilsa_pkg::OP_CARRY_AND_INVERTED_BIT) |=>
			!mem_wr_o [*4];
	endproperty
	a_test_ro: assert property (p_test_ro) else $error("bit test wrote memory");

	c_div: cover property (div_fire && op_q == ilsa_pkg::OP_SIGNED_DIVIDE);
	c_rmw: cover property (mem_wr_o);
	c_rotc: cover property (exec_fire && op_q == ilsa_pkg::OP_ROTATE_CARRY_RIGHT);
endmodule

// >>> ilsa_mem_model.sv
// behavioural byte memory on the far side of the datapath memory port
// assumes: read data are wanted only in the cycle after the read strobe
`timescale 1ns/10ps

// ==========================================================================
// memory model
module ilsa_mem_model (
	input wire logic sys_clk_i, // core clock
	input wire logic mem_rd_i, // read strobe
	input wire logic mem_wr_i, // write strobe
	input wire logic [23:0] mem_addr_i, // byte address
	input wire logic [7:0] mem_wdata_i, // write byte
	output logic [7:0] mem_rdata_o // read byte
);
	logic [7:0] mem_q [0:15];
	initial mem_rdata_o = 8'h00;
	// data turn over outside the valid cycle so a late sample cannot match
	always @(posedge sys_clk_i) begin
		mem_rdata_o <= mem_rd_i ? mem_q[mem_addr_i[3:0]] : ~mem_rdata_o;
		if (mem_wr_i) begin
			mem_q[mem_addr_i[3:0]] <= mem_wdata_i;
		end
	end
endmodule

// >>> tb_integer_logic_shift_bit_alu.sv
// self-checking bench of the datapath with a byte memory model
// assumes: ilsa_pkg, ilsa_alu and ilsa_mem_model compiled before it
`timescale 1ns/10ps

// ==========================================================================
// bench top
module tb_integer_logic_shift_bit_alu;
	typedef struct packed {logic [4:0] op; logic [1:0] sz; logic [3:0] d; logic [3:0] s;
		logic u; logic [31:0] a; logic [31:0] b; logic [31:0] e;} ilsa_row_t;
	// op, size, dst, src, literal, dst value, src value, dst afterwards
	localparam ilsa_row_t ROWS [23] = '{
		'{5'h06,2'h2,4'h0,4'h1,1'h0,32'hf0f01234,32'hff00ff00,32'hf0001200},
		'{5'h07,2'h0,4'h8,4'h1,1'h1,32'h1200,32'h0f,32'h120f},
		'{5'h08,2'h1,4'h0,4'h1,1'h0,32'hffff,32'h0f0f,32'hf0f0},
		'{5'h09,2'h2,4'h0,4'h1,1'h0,32'hff,32'h0,32'hffffff00},
		'{5'h03,2'h2,4'h0,4'h1,1'h0,32'h1,32'h0,32'hffffffff},
		'{5'h04,2'h1,4'h0,4'h1,1'h0,32'h80,32'h0,32'hff80},
		'{5'h05,2'h2,4'h0,4'h1,1'h0,32'hffff8000,32'h0,32'h8000},
		'{5'h0a,2'h0,4'h8,4'h1,1'h0,32'h41,32'h0,32'h82},
		'{5'h0b,2'h0,4'h8,4'h1,1'h0,32'h81,32'h0,32'hc0},
		'{5'h0c,2'h1,4'h0,4'h1,1'h0,32'h8001,32'h0,32'h2},
		'{5'h0d,2'h2,4'h0,4'h1,1'h0,32'h80000001,32'h0,32'h40000000},
		'{5'h0f,2'h0,4'h8,4'h1,1'h0,32'h81,32'h0,32'hc0},
		'{5'h10,2'h0,4'h8,4'h1,1'h0,32'h80,32'h0,32'h01},
		'{5'h11,2'h0,4'h8,4'h1,1'h0,32'h00,32'h0,32'h80},
		'{5'h00,2'h0,4'h0,4'h9,1'h0,32'h64,32'h07,32'h020e},
		'{5'h01,2'h0,4'h0,4'h9,1'h0,32'hff9c,32'h07,32'hfef2},
		'{5'h00,2'h1,4'h0,4'h1,1'h0,32'h10000,32'h3,32'h15555},
		'{5'h12,2'h0,4'h8,4'h1,1'h1,32'h0,32'h3,32'h08},
		'{5'h13,2'h0,4'h8,4'h9,1'h0,32'hff,32'h2,32'hfb},
		'{5'h02,2'h2,4'h0,4'h1,1'h0,32'h5,32'h5,32'h5},
		'{5'h0e,2'h0,4'h8,4'h1,1'h0,32'h81,32'h0,32'h03},
		'{5'h14,2'h0,4'h8,4'h1,1'h1,32'h0f,32'h1,32'h0d},
		'{5'h04,2'h2,4'h0,4'h1,1'h0,32'h8000,32'h0,32'hffff8000}};
	logic sys_clk_i, sys_rst_i, cmd_valid_i, cmd_use_imm_i, cmd_mem_i, reg_wr_i, reg_rd_i;
	logic [4:0] cmd_op_i;
	logic [1:0] cmd_size_i;
	logic [3:0] cmd_dst_i, cmd_src_i, reg_addr_i, flags_o;
	logic [31:0] cmd_imm_i, reg_wdata_i, reg_rdata_o;
	logic [23:0] cmd_mem_addr_i, mem_addr_o;
	logic [7:0] mem_rdata_i, mem_wdata_o;
	logic cmd_ready_o, done_o, mem_rd_o, mem_wr_o;
	int n_mismatch = 0;
	int n_compared = 0;

	ilsa_alu ilsa_alu_i (.sys_clk_i, .sys_rst_i, .cmd_valid_i, .cmd_op_i, .cmd_size_i,
		.cmd_dst_i, .cmd_src_i, .cmd_use_imm_i, .cmd_imm_i, .cmd_mem_i, .cmd_mem_addr_i,
		.cmd_ready_o, .done_o, .flags_o, .mem_rd_o, .mem_wr_o, .mem_addr_o, .mem_wdata_o,
		.mem_rdata_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o);
	ilsa_mem_model ilsa_mem_model_i (.sys_clk_i, .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o),
		.mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));

	// ======================================================================
	// shared tasks; each strobe task leaves one idle edge so no signal is set twice
	task end_sim;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
			n_mismatch++;
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task rdc(input logic [3:0] a, input logic [31:0] e);
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		@(negedge sys_clk_i);
		chk(reg_rdata_o, e);
	endtask
	// a nonzero memory address selects the memory operand
	task cmd(input logic [4:0] op, input logic [1:0] sz, input logic [3:0] d,
		input logic [3:0] s, input logic u, input logic [31:0] imm, input logic [23:0] ma);
		int k;
		@(posedge sys_clk_i);
		cmd_valid_i <= 1'b1;
		cmd_op_i <= op;
		cmd_size_i <= sz;
		cmd_dst_i <= d;
		cmd_src_i <= s;
		cmd_use_imm_i <= u;
		cmd_imm_i <= imm;
		cmd_mem_i <= |ma;
		cmd_mem_addr_i <= ma;
		@(posedge sys_clk_i);
		cmd_valid_i <= 1'b0;
		for (k = 0; k < 50 && done_o !== 1'b1; k++) @(negedge sys_clk_i);
		chk(32'(done_o), 32'h1);
	endtask

	// ======================================================================
	// clock and watchdog; the run needs well under 3000 cycles
	initial begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		#125000;
		n_mismatch++;
		end_sim;
	end

	// ======================================================================
	// main sequence
	initial begin
		sys_rst_i = 1'b1;
		{cmd_valid_i, cmd_use_imm_i, cmd_mem_i, reg_wr_i, reg_rd_i} = '0;
		{cmd_op_i, cmd_size_i, cmd_dst_i, cmd_src_i, reg_addr_i} = '0;
		{cmd_imm_i, reg_wdata_i, cmd_mem_addr_i} = '0;
		ilsa_mem_model_i.mem_q[5] = 8'h01;
		ilsa_mem_model_i.mem_q[6] = 8'h10;
		repeat (6) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		@(negedge sys_clk_i);
		chk({27'h0, cmd_ready_o, flags_o}, 32'h10);
		wr(4'h9, 32'h1234);
		rdc(4'h9, 32'h0);
		foreach (ROWS[i]) begin
			wr(4'h0, ROWS[i].a);
			wr(4'h1, ROWS[i].b);
			cmd(ROWS[i].op, ROWS[i].sz, ROWS[i].d, ROWS[i].s, ROWS[i].u, ROWS[i].b, 24'h0);
			rdc(4'h0, ROWS[i].e);
		end
		// compare with borrow, then bit test and the memory bit forms
		wr(4'h0, 32'h3);
		wr(4'h1, 32'h5);
		cmd(5'h02, 2'h2, 4'h0, 4'h1, 1'h0, 32'h0, 24'h0);
		chk(32'(flags_o), 32'h9);
		cmd(5'h15, 2'h0, 4'h8, 4'h1, 1'h1, 32'h2, 24'h0);
		chk(32'(flags_o), 32'hd);
		rdc(4'h0, 32'h3);
		cmd(5'h16, 2'h0, 4'h8, 4'h1, 1'h1, 32'h2, 24'h0);
		chk(32'(flags_o), 32'hc);
		wr(4'h8, 32'hd);
		cmd(5'h17, 2'h0, 4'h8, 4'h1, 1'h1, 32'h0, 24'h5);
		chk(32'(flags_o), 32'hc);
		cmd(5'h12, 2'h0, 4'h8, 4'h1, 1'h1, 32'h3, 24'h6);
		@(posedge sys_clk_i);
		#1;
		chk(32'(ilsa_mem_model_i.mem_q[5]), 32'h01);
		chk(32'(ilsa_mem_model_i.mem_q[6]), 32'h18);
		// reset in mid-run clears flags and registers
		@(posedge sys_clk_i);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		@(negedge sys_clk_i);
		chk({27'h0, cmd_ready_o, flags_o}, 32'h10);
		rdc(4'h0, 32'h0);
		end_sim;
	end
endmodule
